/* rtl/motion_status_pkg.sv */
// constants, types and command codes of the axis status and flag registers
// assumes one device clock; the serial link decoder hands over command words
package motion_status_pkg;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [15:0] CODE_LATCH = 16'h0029;
  localparam logic [15:0] CODE_RD_CMD_LATCH = 16'h00ed;
  localparam logic [15:0] CODE_RD_MECH_LATCH = 16'h00ee;
  localparam logic [15:0] CODE_RD_DEV_LATCH = 16'h00ef;
  localparam logic [15:0] CODE_RD_POS_COUNT = 16'h00f4;
  localparam logic [15:0] CODE_RD_SPEED = 16'h00f5;
  localparam logic [15:0] CODE_RD_STATUS = 16'h00f1;
  localparam logic [15:0] CODE_RD_ERROR = 16'h00f2;
  localparam logic [15:0] CODE_RD_EVENT = 16'h00f3;
  localparam logic [15:0] CODE_WR_ERROR = 16'h00bd;
  localparam logic [15:0] CODE_WR_EVENT = 16'h00be;

  // ****************************************
  // widths
  // ****************************************
  localparam int PIN_W = 21;
  localparam int CNT_W = 28;
  localparam int ERR_W = 23;
  localparam int EVT_W = 17;

  // ****************************************
  // flag bit positions and sources
  // ****************************************
  localparam int ERR_OVERRIDE = 12;
  localparam int ERR_ENC_DOUBLE = 13;
  localparam int ERR_MAN_DOUBLE = 14;
  localparam int ERR_INTERP = 15;
  localparam int ERR_NEXT_START = 22;
  localparam int EVT_CLR = 8;
  localparam int EVT_LTC = 9;
  localparam int EVT_ORG = 10;
  localparam int EVT_SD = 11;
  localparam int EVT_STA = 12;
  localparam int EVT_PREREG = 15;
  localparam int EVT_BUF_EMPTY = 16;
  // error bits driven by the motion core: 0..10 and 16..21
  localparam logic [ERR_W-1:0] ERR_CORE_MASK = 23'h3f07ff;
  // event bits driven by the motion core: 0..7, 13, 14
  localparam logic [EVT_W-1:0] EVT_CORE_MASK = 17'h060ff;

  localparam logic [3:0] PHASE_STOPPED = 4'h0;
  localparam logic [1:0] OCC_EMPTY = 2'h0;

  typedef enum logic [1:0] {
    INTERP_NONE = 2'h0,
    INTERP_LINEAR = 2'h1,
    INTERP_CIRCULAR = 2'h2
  } interp_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] code;
    logic [31:0] wdata;
  } cmd_t;

  typedef struct packed {
    logic alarm_input;
    logic pos_end_limit_input;
    logic neg_end_limit_input;
    logic origin_input;
    logic slowdown_input;
    logic start_input;
    logic stop_input;
    logic emergency_input;
    logic position_change_input;
    logic index_input;
    logic counter_clear_input;
    logic latch_input;
    logic in_position_input;
    logic [3:0] general_phase_input;
    logic encoder_phase_a;
    logic encoder_phase_b;
    logic manual_pulse_phase_a;
    logic manual_pulse_phase_b;
  } pins_t;

  typedef struct packed {
    logic [CNT_W-1:0] cmd_pos;
    logic [CNT_W-1:0] mech_pos;
    logic [15:0] deviation;
    logic [16:0] speed;
    logic [3:0] ez_count;
    logic [2:0] idle_count;
    logic [3:0] operation_phase_code;
    logic direction_status;
    logic slowdown_latched_status;
    logic error_clear_output;
    logic [2:0] cmp_match;
    logic pulse_output_status;
    logic [1:0] cmp3_buffer_occupancy;
    logic [1:0] operation_buffer_occupancy;
    logic preregister_full_flag;
    logic latch_source_select;
    logic flag_clear_mode;
    logic [EVT_W-1:0] event_cause_enable;
    logic [ERR_W-1:0] error_causes;
    logic [EVT_W-1:0] event_causes;
    logic pos_mode;
    logic pos_load;
    logic pulse_out;
    logic position_override_write;
    logic next_start_write;
    logic start_write;
    interp_t interp;
    logic [CNT_W-1:0] feed_amount_register;
    logic [CNT_W-1:0] second_axis_feed_amount;
    logic [CNT_W-1:0] circular_centre;
    logic [CNT_W-1:0] second_axis_circular_centre;
  } core_t;

endpackage

/* rtl/motion_status_regs.sv */
// read-side latch, status, flag and counter registers of one motor axis
// assumes command words arrive decoded from the serial link on clk,
// core signals share clk, pins are asynchronous and pass pin_sync
//
// Functional notes
// RULE1: latch trigger copies command position counter, sign-extended, into first latch.
// RULE2: same triggers copy mechanical position counter into second latch.
// RULE3: third latch takes deviation counter, or current speed when source select is one.
// RULE4: deviation latch sign-extends bit 15; speed latch zeroes bits 31 to 17.
// RULE5: status bits 3..0 report the operating phase code.
// RULE6: status bits 5..19 mirror live input and output states.
// RULE7: slowdown shown latched in bit 9 and raw in bit 10.
// RULE8: comparator matches bits 20..22, pulse output 23, phase inputs 24..27.
// RULE9: comparator 3 buffer occupancy reported in bits 29..28.
// RULE10: operation buffer occupancy reported in bits 31..30.
// RULE11: error bits 0..8 set on stops by comparators, limits and stop inputs.
// RULE12: error bits 9, 10, 12 for overflow, watchdog, override while stopped.
// RULE13: error bits 13, 14, 18 for double edges and sync loss; no stop.
// RULE14: error bits 16, 17, 19..21 for axis, range and link monitor stops.
// RULE15: bad interpolation start sets error bit 15 and stops all axes.
// RULE16: next-start write while stopped sets error bit 22.
// RULE17: clear mode zero: reading clears all flags; written ones also clear.
// RULE18: clear mode one: only written ones clear flags.
// RULE19: controller should keep clear mode at one against retry loss.
// RULE20: event bits 0..16 set only where the cause enable bit is set.
// RULE21: event 15 on prereg becoming free, 16 on buffer emptying.
// RULE22: positioning counter loads feed magnitude, counts down per pulse to zero.
// RULE23: clear mode bit chooses whether flag reads clear automatically.
// RULE24: writes to read-only codes ignored; undefined bits read zero.
module motion_status_regs
  import motion_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire cmd_t cmd,
  input wire pins_t pins,
  input wire core_t core,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic stop_all_axes
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0] cmd_latch;
    logic [31:0] mech_latch;
    logic [31:0] dev_latch;
    logic [CNT_W-1:0] pos_count;
    logic [31:0] rd_data;
    logic rd_valid;
    logic stop_all;
    pins_t prev_pins;
    logic prev_prereg_full;
    logic [1:0] prev_op_occ;
  } regs_state_t;

  regs_state_t s;
  regs_state_t next_s;
  pins_t p;
  logic [PIN_W-1:0] pins_synced;
  logic [ERR_W-1:0] error_flags;
  logic [EVT_W-1:0] event_flags;
  logic [ERR_W-1:0] err_set;
  logic [EVT_W-1:0] evt_raw;
  logic [EVT_W-1:0] evt_set;
  logic [31:0] status_word;
  logic [31:0] speed_word;
  logic latch_trig;
  logic stopped;
  logic interp_bad;
  logic rd_cmd;
  logic err_rd;
  logic evt_rd;
  logic auto_clear;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] sext28(input logic [CNT_W-1:0] v);
    return {{(32 - CNT_W){v[CNT_W-1]}}, v};
  endfunction

  function automatic logic [CNT_W-1:0] magnitude(input logic [CNT_W-1:0] v);
    return v[CNT_W-1] ? CNT_W'(-v) : v;
  endfunction

  function automatic logic both_changed(input logic a, input logic pa,
                                        input logic b, input logic pb);
    return (a ^ pa) & (b ^ pb);
  endfunction

  // ****************************************
  // pin synchroniser
  // ****************************************
  pin_sync #(
    .W(PIN_W)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(pins),
    .q(pins_synced)
  );

  assign p = pins_t'(pins_synced);

  // ****************************************
  // decode and status words
  // ****************************************
  // command decode and shared conditions
  always_comb begin
    stopped = core.operation_phase_code == PHASE_STOPPED;
    rd_cmd = ce && cmd.valid && !cmd.write;
    err_rd = rd_cmd && (cmd.code == CODE_RD_ERROR);
    evt_rd = rd_cmd && (cmd.code == CODE_RD_EVENT);
    auto_clear = !core.flag_clear_mode; // see RULE23
    latch_trig = (p.latch_input && !s.prev_pins.latch_input) // see RULE1
               || (p.origin_input && !s.prev_pins.origin_input)
               || (cmd.valid && cmd.code == CODE_LATCH);
  end

  // extended status word layout
  always_comb begin
    status_word = {core.operation_buffer_occupancy, // see RULE10
                   core.cmp3_buffer_occupancy, // see RULE9
                   p.general_phase_input, // see RULE8
                   core.pulse_output_status,
                   core.cmp_match,
                   p.in_position_input, // see RULE6
                   p.latch_input,
                   p.counter_clear_input,
                   p.index_input,
                   core.error_clear_output,
                   p.position_change_input,
                   p.emergency_input,
                   p.stop_input,
                   p.start_input,
                   p.slowdown_input, // see RULE7
                   core.slowdown_latched_status,
                   p.origin_input,
                   p.neg_end_limit_input,
                   p.pos_end_limit_input,
                   p.alarm_input,
                   core.direction_status,
                   core.operation_phase_code}; // see RULE5
    speed_word = {5'h00, core.idle_count, core.ez_count, 3'h0,
                  stopped ? 17'h00000 : core.speed}; // see RULE24
  end

  // ****************************************
  // flag causes
  // ****************************************
  // interpolation start data check
  always_comb begin
    interp_bad = 1'b0;
    if (core.start_write) begin
      case (core.interp)
        INTERP_LINEAR: begin
          interp_bad = (core.feed_amount_register == '0)
                     && (core.second_axis_feed_amount == '0); // see RULE15
        end
        INTERP_CIRCULAR: begin
          interp_bad = ((core.circular_centre == '0)
                     && (core.second_axis_circular_centre == '0))
                     || ((core.feed_amount_register == core.circular_centre)
                     && (core.second_axis_feed_amount
                         == core.second_axis_circular_centre));
        end
        default: begin
          interp_bad = 1'b0;
        end
      endcase
    end
  end

  // error set vector: core stop causes plus locally detected ones
  always_comb begin
    err_set = core.error_causes & ERR_CORE_MASK; // see RULE11 see RULE12 see RULE14
    err_set[ERR_OVERRIDE] = core.position_override_write && stopped; // see RULE12
    // double edges are only reported; no stop request follows
    err_set[ERR_ENC_DOUBLE] = both_changed(p.encoder_phase_a, s.prev_pins.encoder_phase_a,
      p.encoder_phase_b, s.prev_pins.encoder_phase_b); // see RULE13
    err_set[ERR_MAN_DOUBLE] = both_changed(p.manual_pulse_phase_a,
      s.prev_pins.manual_pulse_phase_a, p.manual_pulse_phase_b,
      s.prev_pins.manual_pulse_phase_b); // see RULE13
    err_set[ERR_INTERP] = interp_bad; // see RULE15
    err_set[ERR_NEXT_START] = core.next_start_write && stopped; // see RULE16
  end

  // event set vector, gated by the cause enables
  always_comb begin
    evt_raw = core.event_causes & EVT_CORE_MASK;
    evt_raw[EVT_CLR] = p.counter_clear_input && !s.prev_pins.counter_clear_input;
    evt_raw[EVT_LTC] = p.latch_input && !s.prev_pins.latch_input;
    evt_raw[EVT_ORG] = p.origin_input && !s.prev_pins.origin_input;
    evt_raw[EVT_SD] = p.slowdown_input && !s.prev_pins.slowdown_input;
    evt_raw[EVT_STA] = p.start_input && !s.prev_pins.start_input;
    evt_raw[EVT_PREREG] = s.prev_prereg_full && !core.preregister_full_flag; // see RULE21
    evt_raw[EVT_BUF_EMPTY] = (s.prev_op_occ != OCC_EMPTY)
                           && (core.operation_buffer_occupancy == OCC_EMPTY);
    evt_set = evt_raw & core.event_cause_enable; // see RULE20
  end

  // ****************************************
  // flag registers
  // ****************************************
  sticky_flags #(
    .W(ERR_W)
  ) u_error_flags (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .set(err_set),
    .read_clear(err_rd && auto_clear), // see RULE17 see RULE18
    .write_clear(ce && cmd.valid && cmd.write && cmd.code == CODE_WR_ERROR),
    .wdata(cmd.wdata[ERR_W-1:0]),
    .flags(error_flags)
  );

  sticky_flags #(
    .W(EVT_W)
  ) u_event_flags (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .set(evt_set),
    .read_clear(evt_rd && auto_clear), // see RULE17 see RULE18
    .write_clear(ce && cmd.valid && cmd.write && cmd.code == CODE_WR_EVENT),
    .wdata(cmd.wdata[EVT_W-1:0]),
    .flags(event_flags)
  );

  // ****************************************
  // latches, counter and read port
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.prev_pins = p;
    next_s.prev_prereg_full = core.preregister_full_flag;
    next_s.prev_op_occ = core.operation_buffer_occupancy;
    next_s.stop_all = interp_bad; // see RULE15
    // latch captures
    if (latch_trig) begin
      next_s.cmd_latch = sext28(core.cmd_pos); // see RULE1
      next_s.mech_latch = sext28(core.mech_pos); // see RULE2
      if (core.latch_source_select) begin
        next_s.dev_latch = {15'h0000, stopped ? 17'h00000 : core.speed}; // see RULE3 see RULE4
      end else begin
        next_s.dev_latch = {{16{core.deviation[15]}}, core.deviation}; // see RULE4
      end
    end
    // positioning counter
    if (core.pos_mode && core.pos_load) begin
      next_s.pos_count = magnitude(core.feed_amount_register); // see RULE22
    end else if (core.pulse_out && s.pos_count != '0) begin
      next_s.pos_count = s.pos_count - CNT_W'(1); // see RULE22
    end
    // read answer; writes to read-only codes change nothing
    next_s.rd_valid = cmd.valid && !cmd.write;
    next_s.rd_data = 32'h00000000;
    if (cmd.valid && !cmd.write) begin
      case (cmd.code)
        CODE_RD_CMD_LATCH: next_s.rd_data = s.cmd_latch;
        CODE_RD_MECH_LATCH: next_s.rd_data = s.mech_latch;
        CODE_RD_DEV_LATCH: next_s.rd_data = s.dev_latch;
        CODE_RD_POS_COUNT: next_s.rd_data = {4'h0, s.pos_count};
        CODE_RD_SPEED: next_s.rd_data = speed_word;
        CODE_RD_STATUS: next_s.rd_data = status_word;
        CODE_RD_ERROR: next_s.rd_data = {9'h000, error_flags};
        CODE_RD_EVENT: next_s.rd_data = {15'h0000, event_flags};
        default: next_s.rd_data = 32'h00000000; // see RULE24
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rd_data = s.rd_data;
  assign rd_valid = s.rd_valid;
  assign stop_all_axes = s.stop_all;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_status_read;
    ce && cmd.valid && !cmd.write && cmd.code == CODE_RD_STATUS;
  endsequence

  sequence s_status_answer;
    rd_valid && rd_data == $past(status_word);
  endsequence

  sequence s_read_clear;
    ce && err_rd && !core.flag_clear_mode && err_set == '0;
  endsequence

  a_latch_cmd_pos: assert property ( // see RULE1
    ce && latch_trig |=> s.cmd_latch == sext28($past(core.cmd_pos)))
    else $error("command position latch wrong");

  a_latch_mech_pos: assert property ( // see RULE2
    ce && latch_trig |=> s.mech_latch == sext28($past(core.mech_pos)))
    else $error("mechanical position latch wrong");

  a_latch_dev_sign: assert property ( // see RULE4
    ce && latch_trig && !core.latch_source_select
    |=> s.dev_latch[31:16] == {16{s.dev_latch[15]}}
        && s.dev_latch[15:0] == $past(core.deviation))
    else $error("deviation latch not sign extended");

  a_latch_speed_top: assert property ( // see RULE3
    ce && latch_trig && core.latch_source_select
    |=> s.dev_latch[31:17] == 15'h0000)
    else $error("speed latch upper bits not zero");

  a_status_answer: assert property ( // see RULE6
    s_status_read |=> s_status_answer)
    else $error("status read answer wrong");

  a_read_clears_all: assert property ( // see RULE17
    s_read_clear ##0 !(cmd.write) |=> error_flags == '0)
    else $error("error flags not cleared by read");

  a_read_keeps: assert property ( // see RULE18
    ce && err_rd && core.flag_clear_mode
    |=> error_flags == ($past(error_flags) | $past(err_set)))
    else $error("error flags cleared by read in keep mode");

  a_interp_stop: assert property ( // see RULE15
    ce && interp_bad |=> stop_all_axes && error_flags[ERR_INTERP])
    else $error("interpolation error not raised");

  a_next_start_err: assert property ( // see RULE16
    ce && core.next_start_write && stopped |=> error_flags[ERR_NEXT_START])
    else $error("next start error not raised");

  a_pos_countdown: assert property ( // see RULE22
    ce && !(core.pos_mode && core.pos_load) && core.pulse_out && s.pos_count != '0
    |=> s.pos_count == $past(s.pos_count) - CNT_W'(1))
    else $error("positioning counter did not step down");

  a_event_gated: assert property ( // see RULE20
    ce && !core.event_cause_enable[EVT_PREREG] && !event_flags[EVT_PREREG]
    |=> !event_flags[EVT_PREREG])
    else $error("disabled event set its flag");

endmodule

/* rtl/pin_sync.sv */
// three-stage synchroniser for a group of pin inputs
// assumes pins are asynchronous; a change is taken once stages two and three agree
module pin_sync
  import motion_status_pkg::*;
#(
  parameter int W = PIN_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // shift, and accept a bit only where the two later stages agree
  always_comb begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.q = (s.s3 & ~(s.s2 ^ s.s3)) | (s.q & (s.s2 ^ s.s3));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign q = s.q;

endmodule

/* rtl/sticky_flags.sv */
// sticky flag register with clear-on-read and write-one-to-clear
// assumes set pulses come from logic on the same clock
module sticky_flags
  import motion_status_pkg::*;
#(
  parameter int W = ERR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic read_clear,
  input wire logic write_clear,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] q;
  } flag_state_t;

  flag_state_t s;
  flag_state_t next_s;
  logic [W-1:0] clr;

  // a set in the clearing cycle survives the clear
  always_comb begin
    next_s = s;
    clr = ({W{read_clear}}) | (write_clear ? wdata : '0);
    next_s.q = (s.q & ~clr) | set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign flags = s.q;

  a_set_survives: assert property (@(posedge clk) disable iff (rst) // see RULE17
    ce |=> (flags & $past(set)) == $past(set))
    else $error("flag set lost in clearing cycle");

endmodule

/* tb/controller_model.sv */
// central controller model: issues one command word at a time on the device clock
// assumes the bench calls send and that ce stays high
module controller_model
  import motion_status_pkg::*;
(
  input wire logic clk,
  output cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus until the first command
  initial begin
    cmd = '0;
  end

  // word stands for exactly one taking edge, then the bus goes idle
  task automatic send(input logic wr, input logic [15:0] code, input logic [31:0] wdata);
    @(posedge clk);
    cmd <= '{1'b1, wr, code, wdata};
    @(posedge clk);
    cmd <= '0;
  endtask
endmodule

/* tb/motion_status_regs_bench.sv */
// self-checking bench of the axis status, latch and flag registers
// assumes controller_model sends commands; the bench drives pins and core
module motion_status_regs_bench
  import motion_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // signals and checking
  // ****
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  cmd_t cmd;
  pins_t pins = '0;
  core_t core = '0;
  logic [31:0] rd_data;
  logic rd_valid;
  logic stop_all_axes;
  int n_fail = 0;
  int compares = 0;
  logic [31:0] expq[$];
  logic [31:0] want;
  logic [31:0] v;
  logic [16:0] m;
  `define check_eq(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h want %h", $time, a, b); end end

  always #20 clk = ~clk;

  controller_model ctl (.clk(clk), .cmd(cmd));
  motion_status_regs DUT (.clk(clk), .rst(rst), .ce(ce), .cmd(cmd), .pins(pins),
    .core(core), .rd_data(rd_data), .rd_valid(rd_valid), .stop_all_axes(stop_all_axes));

  // each answer takes the oldest noted expectation
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      want = (expq.size() > 0) ? expq.pop_front() : 32'hxxxxxxxx;
      `check_eq(rd_data, want)
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rd(input logic [15:0] code, input logic [31:0] exp);
    expq.push_back(exp);
    ctl.send(1'b0, code, 32'h0);
  endtask

  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    wt(3000);
    n_fail++;
    test_done;
  end

  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(32'h5804));
    wt(10);
    rst <= 1'b0;
    // latch by command, latch pin, origin pin; speed source while running and stopped
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      core.cmd_pos <= CNT_W'($urandom);
      core.mech_pos <= CNT_W'($urandom);
      core.deviation <= 16'($urandom);
      core.speed <= 17'($urandom_range(100000));
      core.latch_source_select <= t[1];
      core.operation_phase_code <= (t == 3) ? PHASE_STOPPED : 4'h9;
      if (t == 0 || t == 3) begin
        ctl.send(1'b1, CODE_LATCH, 32'h0);
      end else begin
        @(posedge clk);
        if (t == 1) pins.latch_input <= 1'b1;
        else pins.origin_input <= 1'b1;
        wt(6);
        pins <= '0;
      end
      rd(CODE_RD_CMD_LATCH, {{4{core.cmd_pos[27]}}, core.cmd_pos});
      rd(CODE_RD_MECH_LATCH, {{4{core.mech_pos[27]}}, core.mech_pos});
      v = t[1] ? ((t == 3) ? 32'h0 : {15'h0, core.speed}) :
        {{16{core.deviation[15]}}, core.deviation};
      rd(CODE_RD_DEV_LATCH, v);
    end
    // read-only latch ignores a write; unmapped code answers zero
    ctl.send(1'b1, CODE_RD_CMD_LATCH, 32'hffffffff);
    rd(CODE_RD_CMD_LATCH, {{4{core.cmd_pos[27]}}, core.cmd_pos});
    rd(16'h00f0, 32'h0);
    // live status word with random pins and core states
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      pins <= pins_t'(PIN_W'($urandom));
      core.operation_phase_code <= 4'($urandom);
      {core.direction_status, core.slowdown_latched_status, core.error_clear_output,
        core.cmp_match, core.pulse_output_status, core.cmp3_buffer_occupancy,
        core.operation_buffer_occupancy} <= 11'($urandom);
      wt(5);
      rd(CODE_RD_STATUS, {core.operation_buffer_occupancy, core.cmp3_buffer_occupancy,
        pins.general_phase_input, core.pulse_output_status, core.cmp_match,
        pins.in_position_input, pins.latch_input, pins.counter_clear_input,
        pins.index_input, core.error_clear_output, pins.position_change_input,
        pins.emergency_input, pins.stop_input, pins.start_input, pins.slowdown_input,
        core.slowdown_latched_status, pins.origin_input, pins.neg_end_limit_input,
        pins.pos_end_limit_input, pins.alarm_input, core.direction_status,
        core.operation_phase_code});
    end
    // errors detected here: override, double edges, bad interpolation, next start
    @(posedge clk);
    pins <= '0;
    core <= '0;
    core.interp <= INTERP_LINEAR;
    core.flag_clear_mode <= 1'b1;
    wt(6);
    ctl.send(1'b1, CODE_WR_ERROR, 32'hffffffff);
    @(posedge clk);
    {core.position_override_write, core.next_start_write, core.start_write} <= 3'h7;
    {pins.encoder_phase_a, pins.encoder_phase_b} <= 2'h3;
    {pins.manual_pulse_phase_a, pins.manual_pulse_phase_b} <= 2'h3;
    @(posedge clk);
    {core.position_override_write, core.next_start_write, core.start_write} <= 3'h0;
    @(negedge clk);
    `check_eq(stop_all_axes, 1'b1)
    // circular start with a zero centre stops all axes too, for one cycle only
    @(posedge clk);
    core.interp <= INTERP_CIRCULAR;
    core.start_write <= 1'b1;
    @(posedge clk);
    core.start_write <= 1'b0;
    @(negedge clk);
    `check_eq(stop_all_axes, 1'b1)
    @(negedge clk);
    `check_eq(stop_all_axes, 1'b0)
    wt(6);
    rd(CODE_RD_ERROR, 32'h0040f000);
    rd(CODE_RD_ERROR, 32'h0040f000);
    ctl.send(1'b1, CODE_WR_ERROR, 32'h0040f000);
    rd(CODE_RD_ERROR, 32'h0);
    // core error causes in clear-on-read mode
    @(posedge clk);
    core.flag_clear_mode <= 1'b0;
    v = $urandom & 32'(ERR_CORE_MASK);
    core.error_causes <= ERR_W'(v);
    @(posedge clk);
    core.error_causes <= '0;
    rd(CODE_RD_ERROR, v);
    rd(CODE_RD_ERROR, 32'h0);
    // every event cause at once under a random enable mask
    @(posedge clk);
    m = 17'($urandom);
    core.event_cause_enable <= m;
    core.operation_buffer_occupancy <= 2'h1;
    core.preregister_full_flag <= 1'b1;
    core.flag_clear_mode <= 1'b1;
    wt(6);
    ctl.send(1'b1, CODE_WR_EVENT, 32'hffffffff);
    @(posedge clk);
    {pins.counter_clear_input, pins.latch_input, pins.origin_input} <= 3'h7;
    {pins.slowdown_input, pins.start_input} <= 2'h3;
    core.event_causes <= EVT_CORE_MASK;
    core.operation_buffer_occupancy <= OCC_EMPTY;
    core.preregister_full_flag <= 1'b0;
    @(posedge clk);
    core.event_causes <= '0;
    wt(6);
    rd(CODE_RD_EVENT, {15'h0, m});
    // positioning counter: stops at zero, counts down per pulse
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      v = k ? $urandom_range(100000, 1000) : 32'd3;
      core.pos_mode <= 1'b1;
      core.feed_amount_register <= CNT_W'(v);
      core.pos_load <= 1'b1;
      @(posedge clk);
      core.pos_load <= 1'b0;
      repeat (5) begin
        @(posedge clk);
        core.pulse_out <= 1'b1;
        @(posedge clk);
        core.pulse_out <= 1'b0;
      end
      rd(CODE_RD_POS_COUNT, k ? v - 32'd5 : 32'h0);
    end
    // pulses with ce low are ignored; a reset in mid-run empties the counter
    @(posedge clk);
    ce <= 1'b0;
    core.pulse_out <= 1'b1;
    wt(3);
    ce <= 1'b1;
    core.pulse_out <= 1'b0;
    rd(CODE_RD_POS_COUNT, v - 32'd5);
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    rd(CODE_RD_POS_COUNT, 32'h0);
    wt(4);
    `check_eq(expq.size(), 0)
    test_done;
  end
endmodule
